/* otpmf_pkg.sv */
// Constants, encodings and the CRC step shared by both ends of the link.
// Assumes one 100 MHz clock on both ends and slot-level signalling.
package otpmf_pkg;
	localparam logic [7:0] CMD_READ_FIELD = 8'hf0;
	localparam logic [7:0] CMD_WRITE_MEM = 8'h0f;
	localparam logic [7:0] CMD_READ_STATUS = 8'haa;
	localparam logic [7:0] CMD_PROGRAM = 8'h5a;
	localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] STATUS_LAST_BYTE = 8'h00;
	localparam int FIELD_BYTES = 192;
	localparam logic [15:0] FIELD_LAST = 16'h00bf;
	localparam logic [15:0] STATUS_LAST = 16'h0007;
	localparam logic [15:0] WRITE_LAST = 16'h00b8;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [2:0] SEG_LAST_IDX = 3'h7;
	localparam logic [7:0] SEG_BYTES = 8'h08;
	localparam logic [1:0] OP_READ_FIELD = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ_STATUS = 2'h2;
	localparam int PROGRAM_PULSE_MINIMUM_US = 2500;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROGRAM_PULSE_MINIMUM_CYC =
		(PROGRAM_PULSE_MINIMUM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// One bit into the x8+x5+x4+1 generator, LSB-first reflected form
	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic b);
		crc8_step = {1'b0, crc[7:1]} ^ ((crc[0] ^ b) ? CRC_POLY_REFL : 8'h00);
	endfunction
endpackage

/* otpmf_link_if.sv */
// Slot-level single-wire link between the bus host and the memory device.
// Assumes bit-slot timing and line electrics are resolved outside.
`timescale 1ns/1ps
interface otpmf_link_if;
	logic bus_reset;
	logic wr_slot;
	logic wr_bit;
	logic rd_slot;
	logic rd_bit;
	logic prog_pulse;
	modport dev (
		input bus_reset,
		input wr_slot,
		input wr_bit,
		input rd_slot,
		input prog_pulse,
		output rd_bit
	);
	modport host (
		output bus_reset,
		output wr_slot,
		output wr_bit,
		output rd_slot,
		output prog_pulse,
		input rd_bit
	);
endinterface

/* otpmf_device.sv */
// Memory-function command handler of the one-time-programmable device.
// Assumes ROM selection is done elsewhere and shown on sel.
//
// Behaviour
// - Field read: F0h, address low, high
// - All bytes travel least significant bit first
// - CRC over command and address returned
// - Host resets and restarts on CRC mismatch; this host resets and ends with err
// - Data streams from address to field end
// - Field end followed by CRC of data
// - After data CRC, reads return ones
// - Reset before field end: no data CRC
// - Write: 0Fh, address, then command CRC
// - Eight data bytes buffered, then CRC
// - Host sends 5Ah, holds pulse 2500 us
// - Pulse ANDs buffer into addressed segment
// - Write address multiple of eight, to 00B8h
// - Reset aborts anything except the pulse
// - Programmed bytes returned; host verifies them
// - Device never checks host CRC
// - Unprogrammed bits read as one
// - Status read: AAh, address, then CRC
// - Status bytes to fixed 00h, then CRC
// - After status CRC, reads return ones
// - Reset ends status read at once
// - Commands ignored until ROM selection
// - CRC polynomial x8+x5+x4+1
`timescale 1ns/1ps
module otpmf_device (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sel,
	input wire logic [55:0] status_bytes,
	otpmf_link_if.dev link
);
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_CMD = 4'h1,
		S_ADLO = 4'h3,
		S_ADHI = 4'h2,
		S_HCRC = 4'h6,
		S_RDAT = 4'h7,
		S_RCRC = 4'h5,
		S_ONES = 4'h4,
		S_WDAT = 4'hc,
		S_WCRC = 4'hd,
		S_PCMD = 4'hf,
		S_PWAIT = 4'he,
		S_VER = 4'ha,
		S_SDAT = 4'hb,
		S_SCRC = 4'h9
	} otpmf_dev_state_t;

	otpmf_dev_state_t st_q;
	logic [2:0] bit_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic [7:0] crc_q;
	logic [7:0] cmd_q;
	logic [15:0] addr_q;
	logic [2:0] idx_q;
	logic pp_q;
	logic [7:0] buf_q [0:7];
	logic [7:0] mem_q [0:otpmf_pkg::FIELD_BYTES-1];

	logic rx_st;
	logic tx_st;
	logic step;
	logic last;
	logic cur_bit;
	logic abort;
	logic crc_upd;
	logic pulse_rise;
	logic pulse_fall;
	logic [7:0] rx_byte;
	logic [7:0] crc_nx;
	logic [15:0] base;

	function automatic logic [7:0] mem_rd(input logic [15:0] a);
		mem_rd = (a <= otpmf_pkg::FIELD_LAST) ? mem_q[a[7:0]] : otpmf_pkg::ERASED_BYTE;
	endfunction

	function automatic logic [7:0] stat_rd(input logic [15:0] a);
		if (a < otpmf_pkg::STATUS_LAST)
			stat_rd = status_bytes[{a[2:0], 3'b000} +: 8];
		else
			stat_rd = otpmf_pkg::STATUS_LAST_BYTE;
	endfunction

	// Line held at programming level cannot carry a reset
	assign abort = link.bus_reset & ~link.prog_pulse;
	assign rx_st = (st_q == S_CMD) || (st_q == S_ADLO) || (st_q == S_ADHI) ||
		(st_q == S_WDAT) || (st_q == S_PCMD);
	assign tx_st = (st_q == S_HCRC) || (st_q == S_RDAT) || (st_q == S_RCRC) ||
		(st_q == S_SDAT) || (st_q == S_SCRC) || (st_q == S_WCRC) || (st_q == S_VER) ||
		(st_q == S_ONES);
	assign step = (link.wr_slot & rx_st) | (link.rd_slot & tx_st);
	assign last = step && (bit_q == otpmf_pkg::BYTE_LAST_BIT);
	assign cur_bit = rx_st ? link.wr_bit : tx_q[0];
	assign rx_byte = {link.wr_bit, rx_q[7:1]};
	assign crc_nx = otpmf_pkg::crc8_step(crc_q, cur_bit);
	assign crc_upd = step && ((st_q == S_CMD) || (st_q == S_ADLO) || (st_q == S_ADHI) ||
		(st_q == S_RDAT) || (st_q == S_SDAT) || (st_q == S_WDAT));
	assign base = {addr_q[15:3], 3'b000};
	assign pulse_rise = (st_q == S_PWAIT) && link.prog_pulse && !pp_q;
	assign pulse_fall = (st_q == S_PWAIT) && pp_q && !link.prog_pulse;
	assign link.rd_bit = tx_q[0];

	always_ff @(posedge clk) begin
		if (!rstn || abort) begin
			st_q <= S_IDLE;
		end else begin
			case (st_q)
				S_IDLE: if (sel) st_q <= S_CMD;
				S_CMD: if (last) begin
					case (rx_byte)
						otpmf_pkg::CMD_READ_FIELD,
						otpmf_pkg::CMD_WRITE_MEM,
						otpmf_pkg::CMD_READ_STATUS: st_q <= S_ADLO;
						default: st_q <= S_ONES;
					endcase
				end
				S_ADLO: if (last) st_q <= S_ADHI;
				S_ADHI: if (last) st_q <= S_HCRC;
				S_HCRC: if (last) begin
					case (cmd_q)
						otpmf_pkg::CMD_READ_FIELD: st_q <= S_RDAT;
						otpmf_pkg::CMD_WRITE_MEM: st_q <= S_WDAT;
						default: st_q <= S_SDAT;
					endcase
				end
				S_RDAT: if (last && addr_q >= otpmf_pkg::FIELD_LAST) st_q <= S_RCRC;
				S_RCRC: if (last) st_q <= S_ONES;
				S_SDAT: if (last && addr_q >= otpmf_pkg::STATUS_LAST) st_q <= S_SCRC;
				S_SCRC: if (last) st_q <= S_ONES;
				S_WDAT: if (last && idx_q == otpmf_pkg::SEG_LAST_IDX) st_q <= S_WCRC;
				// Proceeds whatever CRC the host computed
				S_WCRC: if (last) st_q <= S_PCMD;
				S_PCMD: if (last) st_q <= (rx_byte == otpmf_pkg::CMD_PROGRAM) ? S_PWAIT : S_ONES;
				S_PWAIT: if (pulse_fall) st_q <= S_VER;
				S_VER: if (last && idx_q == otpmf_pkg::SEG_LAST_IDX) st_q <= S_ONES;
				S_ONES: st_q <= S_ONES;
				default: st_q <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || abort || st_q == S_IDLE) begin
			bit_q <= 3'h0;
			rx_q <= otpmf_pkg::ERASED_BYTE;
		end else if (step) begin
			bit_q <= bit_q + 3'h1;
			if (rx_st) rx_q <= rx_byte;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || abort) begin
			cmd_q <= 8'h00;
			addr_q <= 16'h0000;
			idx_q <= 3'h0;
		end else begin
			if (st_q == S_CMD && last) cmd_q <= rx_byte;
			if (st_q == S_ADLO && last) addr_q[7:0] <= rx_byte;
			if (st_q == S_ADHI && last) addr_q[15:8] <= rx_byte;
			if ((st_q == S_RDAT || st_q == S_SDAT) && last) addr_q <= addr_q + 16'h0001;
			if (st_q == S_HCRC || st_q == S_PWAIT) idx_q <= 3'h0;
			else if ((st_q == S_WDAT || st_q == S_VER) && last) idx_q <= idx_q + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || abort || st_q == S_IDLE) begin
			crc_q <= otpmf_pkg::CRC_INIT;
		end else if (st_q == S_HCRC && last) begin
			crc_q <= otpmf_pkg::CRC_INIT; // Data CRC starts fresh
		end else if (crc_upd) begin
			crc_q <= crc_nx;
		end
	end

	// Unloaded slots shift in ones, so a finished byte leaves the line released
	always_ff @(posedge clk) begin
		if (!rstn || abort) begin
			tx_q <= otpmf_pkg::ERASED_BYTE;
		end else if (st_q == S_ADHI && last) begin
			tx_q <= crc_nx;
		end else if (st_q == S_HCRC && last) begin
			if (cmd_q == otpmf_pkg::CMD_READ_FIELD) tx_q <= mem_rd(addr_q);
			else if (cmd_q == otpmf_pkg::CMD_READ_STATUS) tx_q <= stat_rd(addr_q);
			else tx_q <= otpmf_pkg::ERASED_BYTE;
		end else if (st_q == S_RDAT && last) begin
			if (addr_q >= otpmf_pkg::FIELD_LAST) tx_q <= crc_nx;
			else tx_q <= mem_rd(addr_q + 16'h0001);
		end else if (st_q == S_SDAT && last) begin
			if (addr_q >= otpmf_pkg::STATUS_LAST) tx_q <= crc_nx;
			else tx_q <= stat_rd(addr_q + 16'h0001);
		end else if (st_q == S_WDAT && last && idx_q == otpmf_pkg::SEG_LAST_IDX) begin
			tx_q <= crc_nx;
		end else if (pulse_fall) begin
			tx_q <= mem_rd(base);
		end else if (st_q == S_VER && last && idx_q != otpmf_pkg::SEG_LAST_IDX) begin
			tx_q <= mem_rd(base + {13'h0000, idx_q + 3'h1});
		end else if (step) begin
			tx_q <= {1'b1, tx_q[7:1]};
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || abort) begin
			for (int i = 0; i < 8; i++) buf_q[i] <= otpmf_pkg::ERASED_BYTE;
		end else if (st_q == S_WDAT && last) begin
			buf_q[idx_q] <= rx_byte;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) pp_q <= 1'b0;
		else pp_q <= link.prog_pulse;
	end

	// Blank part at power-up; only the programming pulse alters it
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < otpmf_pkg::FIELD_BYTES; i++)
				mem_q[i] <= otpmf_pkg::ERASED_BYTE;
		end else if (pulse_rise && base <= otpmf_pkg::WRITE_LAST) begin
			for (int i = 0; i < 8; i++)
				mem_q[base[7:0] + 8'(i)] <= mem_q[base[7:0] + 8'(i)] & buf_q[i];
		end
	end
endmodule // otpmf_device

/* otpmf_host.sv */
// Bus host end: runs one memory-function transaction per start request.
// Assumes ROM selection of the device is arranged outside after each reset.
`timescale 1ns/1ps
module otpmf_host #(
	parameter int PROG_CYCLES = otpmf_pkg::PROGRAM_PULSE_MINIMUM_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [1:0] op,
	input wire logic [15:0] addr,
	input wire logic [63:0] wdata,
	output logic busy,
	output logic done,
	output logic err,
	output logic rd_valid,
	output logic [7:0] rd_byte,
	otpmf_link_if.host link
);
	typedef enum logic [3:0] {
		H_IDLE = 4'h0,
		H_RST = 4'h1,
		H_CMD = 4'h3,
		H_ALO = 4'h2,
		H_AHI = 4'h6,
		H_CRC1 = 4'h7,
		H_DATA = 4'h5,
		H_CRC2 = 4'h4,
		H_PCMD = 4'hc,
		H_PULSE = 4'hd,
		H_VER = 4'hf,
		H_END = 4'he
	} otpmf_host_state_t;

	otpmf_host_state_t st_q;
	logic [1:0] op_q;
	logic [15:0] addr_q;
	logic [63:0] wd_q;
	logic [63:0] wexp_q;
	logic [7:0] sh_q;
	logic [7:0] hcrc_q;
	logic [7:0] cnt_q;
	logic [2:0] bit_q;
	logic [17:0] pcnt_q;
	logic fail_q;
	logic wr_slot_q;
	logic wr_bit_q;
	logic rd_slot_q;
	logic bus_reset_q;
	logic prog_q;

	logic is_wr;
	logic is_tx;
	logic is_rx;
	logic act;
	logic hlast;
	logic hbit;
	logic bad_addr;
	logic [7:0] rx_byte;

	assign is_wr = (op_q == otpmf_pkg::OP_WRITE);
	assign is_tx = (st_q == H_CMD) || (st_q == H_ALO) || (st_q == H_AHI) ||
		(st_q == H_PCMD) || (st_q == H_DATA && is_wr);
	assign is_rx = (st_q == H_CRC1) || (st_q == H_CRC2) || (st_q == H_VER) ||
		(st_q == H_DATA && !is_wr);
	assign act = wr_slot_q | rd_slot_q;
	assign hlast = act && (bit_q == otpmf_pkg::BYTE_LAST_BIT);
	assign hbit = rd_slot_q ? link.rd_bit : wr_bit_q;
	assign rx_byte = {hbit, sh_q[7:1]};
	// Aligned, in-range write addresses only; read ops bounded by their field, op 3 refused
	assign bad_addr = (op == otpmf_pkg::OP_WRITE) ?
		(addr > otpmf_pkg::WRITE_LAST || addr[2:0] != 3'h0) :
		(op == otpmf_pkg::OP_READ_STATUS) ? (addr > otpmf_pkg::STATUS_LAST) :
		(op == otpmf_pkg::OP_READ_FIELD) ? (addr > otpmf_pkg::FIELD_LAST) : 1'b1;

	assign link.wr_slot = wr_slot_q;
	assign link.wr_bit = wr_bit_q;
	assign link.rd_slot = rd_slot_q;
	assign link.bus_reset = bus_reset_q;
	assign link.prog_pulse = prog_q;

	// Slots every other cycle keep the decision cycle free of a live slot
	always_ff @(posedge clk) begin
		if (!rstn || act) begin
			wr_slot_q <= 1'b0;
			rd_slot_q <= 1'b0;
			wr_bit_q <= 1'b1;
		end else begin
			wr_slot_q <= is_tx;
			rd_slot_q <= is_rx;
			wr_bit_q <= is_tx ? sh_q[0] : 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || st_q == H_RST) bit_q <= 3'h0;
		else if (act) bit_q <= bit_q + 3'h1;
	end

	always_ff @(posedge clk) begin
		if (!rstn || st_q == H_RST) hcrc_q <= otpmf_pkg::CRC_INIT;
		else if (st_q == H_CRC1 && hlast) hcrc_q <= otpmf_pkg::CRC_INIT;
		else if (act && (st_q == H_CMD || st_q == H_ALO || st_q == H_AHI || st_q == H_DATA))
			hcrc_q <= otpmf_pkg::crc8_step(hcrc_q, hbit);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q <= H_IDLE;
			op_q <= otpmf_pkg::OP_READ_FIELD;
			addr_q <= 16'h0000;
			wd_q <= 64'h0;
			wexp_q <= 64'h0;
			sh_q <= otpmf_pkg::ERASED_BYTE;
			cnt_q <= 8'h00;
			pcnt_q <= 18'h00000;
			fail_q <= 1'b0;
			bus_reset_q <= 1'b0;
			prog_q <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			err <= 1'b0;
			rd_valid <= 1'b0;
			rd_byte <= 8'h00;
		end else begin
			done <= 1'b0;
			rd_valid <= 1'b0;
			bus_reset_q <= 1'b0;
			if (act) sh_q <= rx_byte;
			case (st_q)
				H_IDLE: if (start) begin
					busy <= 1'b1;
					op_q <= op;
					addr_q <= addr;
					wd_q <= wdata;
					wexp_q <= wdata;
					fail_q <= bad_addr;
					if (op == otpmf_pkg::OP_WRITE) cnt_q <= otpmf_pkg::SEG_BYTES;
					else if (op == otpmf_pkg::OP_READ_STATUS)
						cnt_q <= 8'(otpmf_pkg::STATUS_LAST - addr + 16'h0001);
					else cnt_q <= 8'(otpmf_pkg::FIELD_LAST - addr + 16'h0001);
					bus_reset_q <= !bad_addr;
					st_q <= bad_addr ? H_END : H_RST;
				end
				H_RST: begin
					st_q <= fail_q ? H_END : H_CMD;
					case (op_q)
						otpmf_pkg::OP_WRITE: sh_q <= otpmf_pkg::CMD_WRITE_MEM;
						otpmf_pkg::OP_READ_STATUS: sh_q <= otpmf_pkg::CMD_READ_STATUS;
						default: sh_q <= otpmf_pkg::CMD_READ_FIELD;
					endcase
				end
				H_CMD: if (hlast) begin
					st_q <= H_ALO;
					sh_q <= addr_q[7:0];
				end
				H_ALO: if (hlast) begin
					st_q <= H_AHI;
					sh_q <= addr_q[15:8];
				end
				H_AHI: if (hlast) st_q <= H_CRC1;
				H_CRC1: if (hlast) begin
					if (rx_byte != hcrc_q) begin
						fail_q <= 1'b1;
						bus_reset_q <= 1'b1;
						st_q <= H_RST;
					end else begin
						st_q <= H_DATA;
						sh_q <= wd_q[7:0];
					end
				end
				H_DATA: if (hlast) begin
					if (!is_wr) begin
						rd_valid <= 1'b1;
						rd_byte <= rx_byte;
					end
					wd_q <= {8'h00, wd_q[63:8]};
					sh_q <= wd_q[15:8];
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h01) st_q <= H_CRC2;
				end
				H_CRC2: if (hlast) begin
					if (rx_byte != hcrc_q) begin
						fail_q <= 1'b1;
						bus_reset_q <= 1'b1;
						st_q <= H_RST;
					end else if (is_wr) begin
						st_q <= H_PCMD;
						sh_q <= otpmf_pkg::CMD_PROGRAM;
					end else begin
						st_q <= H_END;
					end
				end
				H_PCMD: if (hlast) begin
					st_q <= H_PULSE;
					prog_q <= 1'b1;
					pcnt_q <= 18'(PROG_CYCLES - 1);
				end
				// No reset is issued while the pulse stands
				H_PULSE: begin
					pcnt_q <= pcnt_q - 18'h00001;
					if (pcnt_q == 18'h00000) begin
						prog_q <= 1'b0;
						cnt_q <= otpmf_pkg::SEG_BYTES;
						st_q <= H_VER;
					end
				end
				H_VER: if (hlast) begin
					rd_valid <= 1'b1;
					rd_byte <= rx_byte;
					// A one left where a zero was written means a failed cell
					if ((rx_byte & ~wexp_q[7:0]) != 8'h00) fail_q <= 1'b1;
					wexp_q <= {8'h00, wexp_q[63:8]};
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h01) begin
						st_q <= H_RST;
						bus_reset_q <= 1'b1;
						if ((rx_byte & ~wexp_q[7:0]) == 8'h00 && !fail_q) st_q <= H_END;
						if ((rx_byte & ~wexp_q[7:0]) == 8'h00 && !fail_q) bus_reset_q <= 1'b0;
						if ((rx_byte & ~wexp_q[7:0]) != 8'h00 || fail_q) fail_q <= 1'b1;
					end
				end
				H_END: begin
					done <= 1'b1;
					err <= fail_q;
					busy <= 1'b0;
					st_q <= H_IDLE;
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end
endmodule // otpmf_host

/* otpmf_assertions.sv */
// Checker for the single-wire link between the host end and the device end.
// Assumes one clock, synchronous active-low reset and sel driven by the bench.
`timescale 1ns/1ps
module otpmf_assertions #(
	parameter int PROG_CYCLES = otpmf_pkg::PROGRAM_PULSE_MINIMUM_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sel,
	input wire logic bus_reset,
	input wire logic wr_slot,
	input wire logic wr_bit,
	input wire logic rd_slot,
	input wire logic rd_bit,
	input wire logic prog_pulse
);
	int prog_cnt_q;
	// Counter, since the pulse is far too long for a repetition
	always_ff @(posedge clk) begin
		if (!rstn || !prog_pulse) begin
			prog_cnt_q <= 0;
		end else begin
			prog_cnt_q <= prog_cnt_q + 1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_reset_frees_line: assert property (bus_reset && !prog_pulse |=> rd_bit [*2])
		else $error("line not released after bus reset");
	a_reset_then_quiet: assert property (bus_reset |=> !wr_slot && !rd_slot)
		else $error("slot right after bus reset");
	a_unsel_reads_one: assert property (rd_slot && !sel |-> rd_bit)
		else $error("unselected device drove a zero");
	a_prog_min_width: assert property ($fell(prog_pulse) && $past(rstn) |->
		prog_cnt_q >= PROG_CYCLES)
		else $error("programming pulse too short");
	a_prog_no_reset: assert property (prog_pulse |-> !bus_reset)
		else $error("bus reset during programming pulse");
	a_prog_no_slots: assert property (prog_pulse |-> !wr_slot && !rd_slot)
		else $error("slot during programming pulse");
	a_slot_gap_kept: assert property (wr_slot || rd_slot |=> !wr_slot && !rd_slot)
		else $error("slots back to back");
	// Verify data may load one or two edges after the pulse falls
	a_answer_after_slot: assert property ($changed(rd_bit) |->
		$past(rd_slot || wr_slot || bus_reset || !rstn) || $past(prog_pulse, 2)
		|| $past(prog_pulse, 3))
		else $error("read line changed without a slot");
	c_program: cover property ($fell(prog_pulse));
	c_unselected: cover property (rd_slot && !sel);
	c_bits: cover property (wr_slot && !wr_bit ##2 wr_slot && wr_bit);
endmodule // otpmf_assertions

/* tb_otp_memory_function_commands.sv */
// Bench joining host and device ends; user side driven, link and results judged.
// Assumes a 100 MHz clock and a shortened programming pulse.
`timescale 1ns/1ps
module tb_otp_memory_function_commands;
	localparam int PROG = 20;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic sel = 1'b1;
	logic [55:0] status_bytes = 56'h5a6978_8796a5b4;
	logic start = 1'b0;
	logic [1:0] op = 2'h0;
	logic [15:0] addr = 16'h0000;
	logic [63:0] wdata = 64'h0;
	logic busy, done, err, rd_valid;
	logic [7:0] rd_byte;
	logic [7:0] mem [0:191];
	logic [7:0] bq [$];
	logic wq [$];
	logic rq [$];
	int failures = 0;
	int num_checks = 0;
	otpmf_link_if link ();
	otpmf_host #(.PROG_CYCLES(PROG)) otpmf_host_inst (.clk(clk), .rstn(rstn), .start(start),
		.op(op), .addr(addr), .wdata(wdata), .busy(busy), .done(done), .err(err),
		.rd_valid(rd_valid), .rd_byte(rd_byte), .link(link.host));
	otpmf_device otpmf_device_inst (.clk(clk), .rstn(rstn), .sel(sel),
		.status_bytes(status_bytes), .link(link.dev));
	otpmf_assertions #(.PROG_CYCLES(PROG)) otpmf_assertions_inst (.clk(clk), .rstn(rstn),
		.sel(sel), .bus_reset(link.bus_reset), .wr_slot(link.wr_slot), .wr_bit(link.wr_bit),
		.rd_slot(link.rd_slot), .rd_bit(link.rd_bit), .prog_pulse(link.prog_pulse));
	initial begin
		forever #5 clk = ~clk;
	end
	// Wire log restarts at each bus reset, so byte 0 is the command
	always @(posedge clk) begin
		if (rd_valid === 1'b1) bq.push_back(rd_byte);
		if (link.bus_reset === 1'b1) wq.delete();
		if (link.bus_reset === 1'b1) rq.delete();
		if (link.wr_slot === 1'b1) wq.push_back(link.wr_bit);
		if (link.rd_slot === 1'b1) rq.push_back(link.rd_bit);
	end
	function automatic logic [7:0] crc(input logic [7:0] b [$]);
		logic [7:0] c;
		c = 8'h00;
		foreach (b[i]) begin
			for (int k = 0; k < 8; k++) begin
				c = {1'b0, c[7:1]} ^ ((c[0] ^ b[i][k]) ? 8'h8c : 8'h00);
			end
		end
		return c;
	endfunction
	function automatic logic [7:0] wbyte(input logic q [$], input int n);
		logic [7:0] r;
		for (int k = 0; k < 8; k++) r[k] = q[8*n + k];
		return r;
	endfunction
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic run(input logic [1:0] o, input logic [15:0] a, input logic [63:0] d);
		int n;
		bq.delete();
		@(posedge clk);
		#1;
		start = 1'b1;
		op = o;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		start = 1'b0;
		chk8("busy", 8'h01, {7'h00, busy});
		n = 0;
		while (done !== 1'b1 && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk8("done", 8'h01, {7'h00, done});
		chk8("idle", 8'h00, {7'h00, busy});
	endtask
	task automatic t_refused();
		logic [17:0] cs [5] = '{{2'h1, 16'h0003}, {2'h1, 16'h00c0}, {2'h2, 16'h0008},
			{2'h0, 16'h00c0}, {2'h3, 16'h0000}};
		foreach (cs[i]) begin
			wq.delete();
			run(cs[i][17:16], cs[i][15:0], 64'h0);
			chk8("refused err", 8'h01, {7'h00, err});
			chk8("refused slots", 8'h00, 8'(wq.size()));
		end
	endtask
	task automatic t_field(input logic [15:0] a);
		logic [7:0] d [$];
		int n;
		n = 192 - int'(a);
		for (int i = 0; i < n; i++) d.push_back(mem[int'(a) + i]);
		run(2'h0, a, 64'h0);
		chk8("err", 8'h00, {7'h00, err});
		chk8("cmd", 8'hf0, wbyte(wq, 0));
		chk8("addr lo", a[7:0], wbyte(wq, 1));
		chk8("addr hi", a[15:8], wbyte(wq, 2));
		chk8("cmd crc", crc('{8'hf0, a[7:0], a[15:8]}), wbyte(rq, 0));
		chk8("count", 8'(n), 8'(bq.size()));
		foreach (d[i]) chk8("data", d[i], bq[i]);
		chk8("data crc", crc(d), wbyte(rq, n + 1));
		// Line level that the next read slot would return
		chk8("ones after crc", 8'h01, {7'h00, link.rd_bit});
	endtask
	task automatic t_write(input logic [15:0] a, input logic [63:0] d);
		logic [7:0] db [$];
		for (int i = 0; i < 8; i++) begin
			db.push_back(d[8*i +: 8]);
			mem[int'(a) + i] &= d[8*i +: 8];
		end
		run(2'h1, a, d);
		chk8("err", 8'h00, {7'h00, err});
		chk8("cmd", 8'h0f, wbyte(wq, 0));
		chk8("cmd crc", crc('{8'h0f, a[7:0], a[15:8]}), wbyte(rq, 0));
		chk8("data crc", crc(db), wbyte(rq, 1));
		chk8("program", 8'h5a, wbyte(wq, 11));
		foreach (db[i]) begin
			chk8("wdata", db[i], wbyte(wq, 3 + i));
			chk8("verify", mem[int'(a) + i], bq[i]);
		end
	endtask
	task automatic t_status(input logic [15:0] a);
		logic [7:0] s [$];
		for (int i = int'(a); i < 7; i++) s.push_back(status_bytes[8*i +: 8]);
		s.push_back(8'h00);
		run(2'h2, a, 64'h0);
		chk8("err", 8'h00, {7'h00, err});
		chk8("cmd", 8'haa, wbyte(wq, 0));
		chk8("cmd crc", crc('{8'haa, a[7:0], a[15:8]}), wbyte(rq, 0));
		foreach (s[i]) chk8("status", s[i], wbyte(rq, i + 1));
		chk8("status crc", crc(s), wbyte(rq, s.size() + 1));
		chk8("ones after status", 8'h01, {7'h00, link.rd_bit});
	endtask
	task automatic t_unselected();
		sel = 1'b0;
		run(2'h0, 16'h0000, 64'h0);
		chk8("unselected err", 8'h01, {7'h00, err});
		chk8("unselected data", 8'h00, 8'(bq.size()));
		sel = 1'b1;
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		repeat (3) @(posedge clk);
		#1;
		rstn = 1'b1;
		t_refused();
		t_field(16'h00bf);
		t_write(16'h00b8, 64'h01234567_89abcdef);
		// Second pass over the same segment can only clear bits
		t_write(16'h00b8, 64'hf0f0f0f0_0f0f0f0f);
		t_write(16'h0000, 64'h5aa53cc3_966900ff);
		t_field(16'h0000);
		t_status(16'h0005);
		t_status(16'h0000);
		t_unselected();
		t_field(16'h00be);
		wrap_up();
	end
	// Whole run needs well under 10000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("CHECK FAILED watchdog expected finish seen hang");
		wrap_up();
	end
endmodule // tb_otp_memory_function_commands
